// ===== common/adc_conv_pkg.sv
// Constants for the converter control and parallel read port.
// Assumes a single 25 MHz clock; all counts are in clk cycles.
package adc_conv_pkg;
  // ****************************************************************
  // Widths
  // ****************************************************************
  localparam int unsigned RESULT_W = 12;
  localparam int unsigned MSB_IDX = 11;
  localparam int unsigned LSB_IDX = 0;
  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned CONV_TIME_NS = 910;
  localparam int unsigned CONV_CYCLES = CONV_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned CONVERT_PULSE_NS = 40;
  localparam int unsigned CONVERT_PULSE_CYCLES =
    (CONVERT_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W = 6;
  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [RESULT_W-1:0] RESULT_RESET = 12'h000;
  localparam logic [CNT_W-1:0] CNT_RESET = 6'h00;
  typedef enum logic [1:0] {ST_IDLE, ST_CONVERT, ST_LATCH} conv_state_t;
endpackage

// ===== verilog/sar_engine.sv
// Successive approximation core: one bit decided per step, MSB first.
// Assumes the comparator input is already synchronised to clk.
module sar_engine
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control
  input wire logic start,
  input wire logic step,
  // Comparator
  input wire logic cmp_above,
  // Result
  output logic [adc_conv_pkg::RESULT_W-1:0] code,
  output logic [adc_conv_pkg::RESULT_W-1:0] trial
);
  logic [adc_conv_pkg::RESULT_W-1:0] code_r;
  logic [adc_conv_pkg::RESULT_W-1:0] mask_r;
  logic [adc_conv_pkg::RESULT_W-1:0] keep;
  // Straight binary: trial is the kept bits with the current mask bit set
  assign trial = code_r | mask_r;
  assign keep = cmp_above ? mask_r : {adc_conv_pkg::RESULT_W{1'b0}};
  assign code = code_r;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      code_r <= adc_conv_pkg::RESULT_RESET;
      mask_r <= adc_conv_pkg::RESULT_RESET;
    end
    else if (start)
    begin
      code_r <= adc_conv_pkg::RESULT_RESET;
      mask_r <= 12'h800;
    end
    else if (step && mask_r != 12'h000)
    begin
      code_r <= code_r | keep;
      mask_r <= mask_r >> 1;
    end
  end
endmodule

// ===== verilog/adc_convert_port.sv
// Converter control and three-state parallel read port.
// Assumes chip select, read/convert and the comparator come from pins.
// What this block does
// - Result bus floats when select high, read/convert low, or converting.
// - Result MSB on bit 11, LSB on bit 0.
// - With select low, read/convert falling holds sample and starts conversion.
// - With select low and idle, read/convert rising drives the bus.
// - With read/convert low, select falling starts a conversion.
// - With read/convert high and idle, select falling drives the bus.
// - Busy low from start until result latched in output register.
// - Valid data on bus when busy rises with select low, read high.
// - Conversion requests while busy low are ignored.
// - Result coded in binary twos complement.
module adc_convert_port
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Host control pins
  input wire logic cs_n,
  input wire logic read_conv,
  // Analog comparator
  input wire logic cmp_above,
  // Result bus
  output logic [adc_conv_pkg::RESULT_W-1:0] result_bits_o,
  output logic [adc_conv_pkg::RESULT_W-1:0] result_bits_oe,
  // Status and sampler
  output logic busy_n,
  output logic hold
);
  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic cs_meta_r, cs_r, rc_meta_r, rc_r, cmp_meta_r, cmp_r;
  logic cs_prev_r, rc_prev_r;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cs_meta_r <= 1'b1;
      cs_r <= 1'b1;
      rc_meta_r <= 1'b1;
      rc_r <= 1'b1;
      cmp_meta_r <= 1'b0;
      cmp_r <= 1'b0;
      cs_prev_r <= 1'b1;
      rc_prev_r <= 1'b1;
    end
    else
    begin
      cs_meta_r <= cs_n;
      cs_r <= cs_meta_r;
      rc_meta_r <= read_conv;
      rc_r <= rc_meta_r;
      cmp_meta_r <= cmp_above;
      cmp_r <= cmp_meta_r;
      cs_prev_r <= cs_r;
      rc_prev_r <= rc_r;
    end
  end
  // ****************************************************************
  // Request decode
  // ****************************************************************
  // Both inputs are ORed: the start is the combination going low
  wire conv_lvl = !cs_r && !rc_r;
  wire conv_lvl_prev = !cs_prev_r && !rc_prev_r;
  wire conv_req = conv_lvl && !conv_lvl_prev;
  adc_conv_pkg::conv_state_t state_r, state_nxt;
  logic [adc_conv_pkg::CNT_W-1:0] cnt_r;
  logic [adc_conv_pkg::RESULT_W-1:0] out_reg_r;
  wire idle = state_r == adc_conv_pkg::ST_IDLE;
  wire start = idle && conv_req;
  wire step = state_r == adc_conv_pkg::ST_CONVERT;
  wire conv_done = step && cnt_r == adc_conv_pkg::CONV_CYCLES[adc_conv_pkg::CNT_W-1:0] - 6'h01;
  wire [adc_conv_pkg::RESULT_W-1:0] code;
  sar_engine u_sar
  (
    .clk(clk),
    .rst_n(rst_n),
    .start(start),
    .step(step),
    .cmp_above(cmp_r),
    .code(code),
    .trial()
  );
  // ****************************************************************
  // Sequencer
  // ****************************************************************
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      adc_conv_pkg::ST_IDLE:
      begin
        if (start)
          state_nxt = adc_conv_pkg::ST_CONVERT;
      end
      adc_conv_pkg::ST_CONVERT:
      begin
        if (conv_done)
          state_nxt = adc_conv_pkg::ST_LATCH;
      end
      // One extra cycle so the output register is written on the edge busy rises
      adc_conv_pkg::ST_LATCH:
      begin
        state_nxt = adc_conv_pkg::ST_IDLE;
      end
      default: state_nxt = adc_conv_pkg::ST_IDLE;
    endcase
  end
  // Drive enable only when select low, read high and idle
  wire drive_nxt = !cs_r && rc_r && (state_nxt == adc_conv_pkg::ST_IDLE);
  // ****************************************************************
  // Next values
  // ****************************************************************
  wire latch_now = state_r == adc_conv_pkg::ST_LATCH;
  wire [adc_conv_pkg::RESULT_W-1:0] result_nxt = code ^ 12'h800;
  wire [adc_conv_pkg::CNT_W-1:0] cnt_nxt = start ? adc_conv_pkg::CNT_RESET : (step ? cnt_r + 6'h01 : cnt_r);
  wire busy_n_nxt = state_nxt == adc_conv_pkg::ST_IDLE;
  wire hold_nxt = state_nxt == adc_conv_pkg::ST_CONVERT;
  wire [adc_conv_pkg::RESULT_W-1:0] oe_nxt = {adc_conv_pkg::RESULT_W{drive_nxt}};
  // New word reaches the bus on the edge busy rises, so the host latch sees it
  wire [adc_conv_pkg::RESULT_W-1:0] data_nxt = latch_now ? result_nxt : out_reg_r;
  // ****************************************************************
  // State registers
  // ****************************************************************
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      state_r <= adc_conv_pkg::ST_IDLE;
    else
      state_r <= state_nxt;
  end
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      cnt_r <= adc_conv_pkg::CNT_RESET;
    else
      cnt_r <= cnt_nxt;
  end
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      out_reg_r <= adc_conv_pkg::RESULT_RESET;
    else if (latch_now)
      out_reg_r <= result_nxt;
  end
  // ****************************************************************
  // Output registers
  // ****************************************************************
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      busy_n <= 1'b1;
    else
      busy_n <= busy_n_nxt;
  end
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      hold <= 1'b0;
    else
      hold <= hold_nxt;
  end
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      result_bits_oe <= {adc_conv_pkg::RESULT_W{1'b0}};
    else
      result_bits_oe <= oe_nxt;
  end
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      result_bits_o <= adc_conv_pkg::RESULT_RESET;
    else
      result_bits_o <= data_nxt;
  end
  // ****************************************************************
  // Checks
  // ****************************************************************
  float_when_busy_a: assert property (@(posedge clk) disable iff (!rst_n)
    !busy_n |-> result_bits_oe == 12'h000) else $error("bus driven while busy");
  float_cs_high_a: assert property (@(posedge clk) disable iff (!rst_n)
    cs_r |=> result_bits_oe == 12'h000) else $error("bus driven with select high");
  busy_on_start_a: assert property (@(posedge clk) disable iff (!rst_n)
    start |=> !busy_n [*8]) else $error("busy not held low");
  busy_release_a: assert property (@(posedge clk) disable iff (!rst_n)
    start |-> ##[20:26] busy_n) else $error("busy never rose");
  data_at_rise_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(busy_n) |-> result_bits_o == out_reg_r) else $error("data not valid at busy rise");
  ignore_busy_a: assert property (@(posedge clk) disable iff (!rst_n)
    !idle && cnt_r != adc_conv_pkg::CNT_RESET |=> cnt_r != adc_conv_pkg::CNT_RESET)
    else $error("request accepted while busy");
  busy_length_a: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(busy_n) |-> ##22 !busy_n ##1 busy_n) else $error("busy length wrong");
  hold_release_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(busy_n) |-> !hold) else $error("hold kept after conversion");
  float_rc_low_a: assert property (@(posedge clk) disable iff (!rst_n)
    !rc_r |=> result_bits_oe == 12'h000) else $error("bus driven in convert mode");
  oe_uniform_a: assert property (@(posedge clk) disable iff (!rst_n)
    result_bits_oe == 12'h000 || result_bits_oe == 12'hfff) else $error("bus enables split");
  data_stable_a: assert property (@(posedge clk) disable iff (!rst_n)
    idle |=> $stable(result_bits_o)) else $error("bus word changed while idle");
  cnt_bound_a: assert property (@(posedge clk) disable iff (!rst_n)
    state_r == adc_conv_pkg::ST_CONVERT |-> cnt_r <= adc_conv_pkg::CONV_CYCLES[adc_conv_pkg::CNT_W-1:0] - 6'h01)
    else $error("conversion overran");
  latch_once_a: assert property (@(posedge clk) disable iff (!rst_n)
    state_r == adc_conv_pkg::ST_LATCH |=> idle) else $error("latch state held");
  hold_in_convert_a: assert property (@(posedge clk) disable iff (!rst_n)
    state_r == adc_conv_pkg::ST_CONVERT && !conv_done |=> hold) else $error("hold dropped early");
  keep_result_a: assert property (@(posedge clk) disable iff (!rst_n)
    state_r != adc_conv_pkg::ST_LATCH |=> $stable(out_reg_r)) else $error("result changed");
  hold_follows_a: assert property (@(posedge clk) disable iff (!rst_n)
    start |=> hold && !busy_n) else $error("hold not entered");
  read_enable_a: assert property (@(posedge clk) disable iff (!rst_n)
    idle && state_nxt == adc_conv_pkg::ST_IDLE && !cs_r && rc_r |=> result_bits_oe == 12'hfff)
    else $error("bus not enabled");
endmodule

// ===== testbench/host_model.sv
// Host side model: drives select and read/convert, latches the bus.
// Assumes the bench calls its tasks; pins change on falling clk edges.
module host_model
(
  // Clock
  input wire logic clk,
  // Device pins
  input wire logic busy_n,
  input wire logic [adc_conv_pkg::RESULT_W-1:0] result_bits_o,
  input wire logic [adc_conv_pkg::RESULT_W-1:0] result_bits_oe,
  output logic cs_n,
  output logic read_conv,
  output logic [adc_conv_pkg::RESULT_W-1:0] latched
);
  timeunit 1ns;
  timeprecision 1ps;
  logic busy_q = 1'b1;
  logic [adc_conv_pkg::RESULT_W-1:0] bus_w;
  // Floating bits read as inverse of last word, so a float never repeats the last word
  assign bus_w = (result_bits_o & result_bits_oe) | (~latched & ~result_bits_oe);
  initial
  begin
    cs_n = 1'b1;
    read_conv = 1'b1;
    latched = 12'h000;
  end
  // Word taken just after busy rises
  always @(posedge clk)
  begin
    if (busy_n && !busy_q)
      latched <= bus_w;
    busy_q <= busy_n;
  end
  task automatic pins(input logic cs, input logic rc);
    @(negedge clk);
    cs_n = cs;
    read_conv = rc;
  endtask
  // Either pin may open the request; held low 4 cycles
  task automatic request(input logic use_cs);
    pins(use_cs, !use_cs);
    pins(1'b0, 1'b0);
    repeat (3) @(negedge clk);
    pins(1'b0, 1'b1);
  endtask
endmodule

// ===== testbench/testbench.sv
// Self-checking bench for the converter port with a host model.
// Assumes the comparator level is held for a whole conversion.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cmp_above = 1'b0;
  logic cs_n, read_conv, busy_n, hold;
  logic [11:0] res_o, res_oe, latched, exp_w;
  logic [11:0] low_r = 12'h000;
  logic [11:0] last_low = 12'h000;
  logic [31:0] lfsr_r = 32'h6f42;
  int mismatches = 0;
  int num_checks = 0;
  always #20 clk = ~clk;
  adc_convert_port i_dut (.clk(clk), .rst_n(rst_n), .cs_n(cs_n), .read_conv(read_conv),
    .cmp_above(cmp_above), .result_bits_o(res_o), .result_bits_oe(res_oe), .busy_n(busy_n), .hold(hold));
  host_model i_host (.clk(clk), .busy_n(busy_n), .result_bits_o(res_o), .result_bits_oe(res_oe),
    .cs_n(cs_n), .read_conv(read_conv), .latched(latched));
  // Length of the last busy-low stretch
  always @(posedge clk)
  begin
    if (busy_n === 1'b0)
      low_r <= low_r + 12'h001;
    else if (low_r != 12'h000)
    begin
      last_low <= low_r;
      low_r <= 12'h000;
    end
  end
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Comparator always above gives the top code, always below the bottom one
  function automatic logic [11:0] expect_word(input logic level);
    return level ? 12'h7ff : 12'h800;
  endfunction
  task automatic check(input logic [11:0] seen, input logic [11:0] exp, input string what);
    num_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("MISMATCH at %0t: %s", $time, what);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic wait_busy(input logic lvl);
    int i;
    for (i = 0; i < 100 && busy_n !== lvl; i++)
    begin
      if (lvl)
        check(res_oe, 12'h000, "bus driven while converting");
      @(negedge clk);
    end
    if (i == 100)
    begin
      mismatches++;
      $display("MISMATCH at %0t: busy wait timed out", $time);
      complete_run();
    end
  endtask
  initial
  begin
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    check({11'h000, busy_n}, 12'h001, "busy after reset");
    check(res_oe, 12'h000, "bus after reset");
    for (int n = 0; n < 6; n++)
    begin
      lfsr_r = lfsr_next(lfsr_r);
      cmp_above = lfsr_r[0];
      exp_w = expect_word(lfsr_r[0]);
      i_host.request(n[0]);
      wait_busy(1'b0);
      check({11'h000, hold}, 12'h001, "hold not entered");
      i_host.pins(1'b0, 1'b0);
      i_host.pins(1'b0, 1'b1);
      wait_busy(1'b1);
      repeat (3) @(negedge clk);
      check(res_o, exp_w, "result word");
      check(res_oe, 12'hfff, "bus not driven in read mode");
      check(latched, exp_w, "word at busy rise");
      check(last_low, 12'h017, "busy low length");
      check({11'h000, hold}, 12'h000, "hold after conversion");
      check({11'h000, busy_n}, 12'h001, "request while busy restarted");
      i_host.pins(1'b1, 1'b1);
      repeat (4) @(negedge clk);
      check(res_oe, 12'h000, "bus driven with select high");
      i_host.pins(1'b0, 1'b1);
      repeat (4) @(negedge clk);
      check(res_oe, 12'hfff, "select fall did not drive bus");
      check(res_o, exp_w, "held word changed");
      i_host.pins(1'b1, 1'b0);
      repeat (4) @(negedge clk);
      check(res_oe, 12'h000, "bus driven in convert mode");
      check({11'h000, busy_n}, 12'h001, "conversion without select");
      $display("test %0d done", n);
    end
    complete_run();
  end
endmodule
